// ---- src/eea_defs.svh ----
/*
 data eeprom access control: register selects, control bit positions,
 reset values and erase/write timing constants.
 assumes the includer runs on one 20 MHz clock.
*/
// Operation
// - timing select 0: erase lasts 3.2 ms, write lasts 2.2 ms
// - timing select 1: erase lasts 3.7 ms, write lasts 3.0 ms
// - erase enable (bit 6) gates erase; hardware clears it after erase
// - erase trigger (bit 5) starts erase only with enable set; self-clears
// - bit 4 picks byte access or 16-byte page access
// - write enable (bit 3) gates write; hardware clears it after write
// - write trigger (bit 2) starts write only with enable set; self-clears
// - read enable (bit 1) gates every read cycle
// - read trigger (bit 0) starts read only with enable set; self-clears
// - byte read puts the addressed byte in the data register, held
// - page read: each read clears trigger and steps address; retrigger reads next
// - page mode: 7 page bits, 4 byte bits; low field saturates at 0FH
// - page buffer clears at reset and on enable falling, not rising
// - page erase: each data write tags current byte then steps address
// - erase starts only when trigger write directly follows enable write
// - erase timed internally; ends clearing trigger, enable, raising request
// - erased page bytes read back as zero
// - 2048-byte array, 11-bit address from low byte and 3-bit high field
// - erase/write end sets eeprom flag and multi-function flag
`ifndef EEA_DEFS_SVH
`define EEA_DEFS_SVH

// register selects
`define EEA_SEL_ADDR_LOW 2'h0
`define EEA_SEL_ADDR_HIGH 2'h1
`define EEA_SEL_DATA 2'h2
`define EEA_SEL_CTRL 2'h3

// control bit positions
`define EEA_B_TIME_SEL 7
`define EEA_B_ERASE_EN 6
`define EEA_B_ERASE_TRIG 5
`define EEA_B_MODE 4
`define EEA_B_WRITE_EN 3
`define EEA_B_WRITE_TRIG 2
`define EEA_B_READ_EN 1
`define EEA_B_READ_TRIG 0

// reset values, low-field limit and erased value
`define EEA_RST_BYTE 8'h00
`define EEA_RST_HIGH 3'h0
`define EEA_LOW_MAX 4'hF
`define EEA_ERASED 8'h00

// timing
`define EEA_CLK_KHZ 20000
`define EEA_ERASE0_US 3200
`define EEA_WRITE0_US 2200
`define EEA_ERASE1_US 3700
`define EEA_WRITE1_US 3000
`define EEA_TMR_W 17

`endif

// ---- src/eea_pkg.sv ----
/*
 data eeprom access control types: sequencer states and module state records.
 assumes eea_defs.svh is available on the include path.
*/
package eea_pkg;

	typedef enum logic [3:0] {
		EEA_IDLE = 4'b0001,
		EEA_READ = 4'b0010,
		EEA_TIMED = 4'b0100,
		EEA_COMMIT = 4'b1000
	} eea_state_type;

	typedef struct packed {
		logic busy;
		logic [16:0] cnt;
		logic done;
	} eea_tmr_type;

	typedef struct packed {
		eea_state_type state;
		logic [7:0] addr_lo;
		logic [2:0] addr_hi;
		logic [7:0] data;
		logic [7:0] ctrl;
		logic [15:0][7:0] pbuf;
		logic [15:0] tag;
		logic [3:0] idx;
		logic op_erase;
		logic arm_erase;
		logic arm_write;
		logic tmr_start;
		logic [16:0] tmr_load;
		logic [7:0] rdata;
		logic irq_flag;
		logic mf_flag;
	} eea_ctl_type;

endpackage

// ---- src/eea_timer.sv ----
/*
 erase/write cycle timer: counts a loaded number of clocks, pulses done.
 assumes start is a one-cycle pulse with a nonzero load.
*/
module eea_timer import eea_pkg::*; (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// control
	input wire logic start_i,
	input wire logic [16:0] load_i,
	output logic done_o
);

	eea_tmr_type q, d;

	always_comb begin
		d = q;
		d.done = 1'b0;
		if (start_i) begin
			d.busy = 1'b1;
			d.cnt = load_i - 17'h00001;
		end else if (q.busy) begin
			if (q.cnt == 17'h00000) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end else begin
				d.cnt = q.cnt - 17'h00001;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign done_o = q.done;

endmodule // eea_timer

// ---- src/eea_array.sv ----
/*
 data eeprom cell array, 2048 bytes, one write port and a registered read port.
 assumes cell contents are undefined until first written.
*/
module eea_array (
	// clock
	input wire logic ref_clk_i,
	// write port
	input wire logic we_i,
	input wire logic [10:0] waddr_i,
	input wire logic [7:0] wdata_i,
	// read port
	input wire logic [10:0] raddr_i,
	output logic [7:0] rdata_o
);

	logic [7:0] mem [0:2047];

	always_ff @(posedge ref_clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end

endmodule // eea_array

// ---- src/eea_ctrl.sv ----
/*
 data eeprom access controller: address pair, data byte and control register,
 byte/page read, page erase with tagging, byte/page write, timed cycles.
 assumes the core's register port presents one write strobe per access.
*/
`include "eea_defs.svh"

module eea_ctrl import eea_pkg::*; #(
	parameter int ERASE0_CYC = `EEA_ERASE0_US * `EEA_CLK_KHZ / 1000,
	parameter int WRITE0_CYC = `EEA_WRITE0_US * `EEA_CLK_KHZ / 1000,
	parameter int ERASE1_CYC = `EEA_ERASE1_US * `EEA_CLK_KHZ / 1000,
	parameter int WRITE1_CYC = `EEA_WRITE1_US * `EEA_CLK_KHZ / 1000
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// register port
	input wire logic [1:0] reg_sel_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// interrupt request flags
	input wire logic irq_flag_clr_i,
	input wire logic mf_flag_clr_i,
	output logic eeprom_irq_flag_o,
	output logic mf_irq_flag_o
);

	////////////////////////////////////////////////////////////////////////
	eea_ctl_type q, d;
	logic tmr_done;
	logic arr_we;
	logic [10:0] arr_waddr;
	logic [7:0] arr_wdata;
	logic [7:0] arr_rdata;
	logic page;
	logic idle;

	assign page = q.ctrl[`EEA_B_MODE];
	assign idle = (q.state == EEA_IDLE) && !q.ctrl[`EEA_B_ERASE_TRIG]
		&& !q.ctrl[`EEA_B_WRITE_TRIG] && !q.ctrl[`EEA_B_READ_TRIG];

	eea_timer u_timer (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.start_i(q.tmr_start),
		.load_i(q.tmr_load),
		.done_o(tmr_done)
	);

	// commit port: page mode walks the buffer, byte mode writes one cell on a write and none on an erase
	always_comb begin
		arr_we = 1'b0;
		arr_waddr = {q.addr_hi, q.addr_lo};
		arr_wdata = q.data;
		if (q.state == EEA_COMMIT) begin
			if (page) begin
				arr_we = q.tag[q.idx];
				arr_waddr = {q.addr_hi, q.addr_lo[7:4], q.idx};
				arr_wdata = q.op_erase ? `EEA_ERASED : q.pbuf[q.idx];
			end else begin
				arr_we = !q.op_erase;
			end
		end
	end

	eea_array u_array (
		.ref_clk_i(ref_clk_i),
		.we_i(arr_we),
		.waddr_i(arr_waddr),
		.wdata_i(arr_wdata),
		.raddr_i({q.addr_hi, q.addr_lo}),
		.rdata_o(arr_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		d.tmr_start = 1'b0;

		// register read view
		case (reg_sel_i)
			`EEA_SEL_ADDR_LOW: d.rdata = q.addr_lo;
			`EEA_SEL_ADDR_HIGH: d.rdata = {5'h00, q.addr_hi};
			`EEA_SEL_DATA: d.rdata = q.data;
			default: d.rdata = q.ctrl;
		endcase

		// register writes
		if (reg_wr_i) begin
			d.arm_erase = 1'b0;
			d.arm_write = 1'b0;
			case (reg_sel_i)
				`EEA_SEL_ADDR_LOW: d.addr_lo = reg_wdata_i;
				`EEA_SEL_ADDR_HIGH: d.addr_hi = reg_wdata_i[2:0];
				`EEA_SEL_DATA: begin
					d.data = reg_wdata_i;
					if (page && idle && !(q.addr_lo[3:0] == `EEA_LOW_MAX && q.tag[`EEA_LOW_MAX])) begin
						d.pbuf[q.addr_lo[3:0]] = reg_wdata_i;
						d.tag[q.addr_lo[3:0]] = 1'b1;
						if (q.addr_lo[3:0] != `EEA_LOW_MAX) begin
							d.addr_lo[3:0] = q.addr_lo[3:0] + 4'h1;
						end
					end
				end
				default: begin
					d.ctrl[`EEA_B_TIME_SEL] = reg_wdata_i[`EEA_B_TIME_SEL];
					d.ctrl[`EEA_B_MODE] = reg_wdata_i[`EEA_B_MODE];
					d.ctrl[`EEA_B_READ_EN] = reg_wdata_i[`EEA_B_READ_EN];
					if (q.state == EEA_IDLE) begin
						d.ctrl[`EEA_B_ERASE_EN] = reg_wdata_i[`EEA_B_ERASE_EN];
						d.ctrl[`EEA_B_WRITE_EN] = reg_wdata_i[`EEA_B_WRITE_EN];
					end
					d.arm_erase = reg_wdata_i[`EEA_B_ERASE_EN] && !reg_wdata_i[`EEA_B_ERASE_TRIG];
					d.arm_write = reg_wdata_i[`EEA_B_WRITE_EN] && !reg_wdata_i[`EEA_B_WRITE_TRIG];
					if (idle) begin
						d.ctrl[`EEA_B_ERASE_TRIG] = reg_wdata_i[`EEA_B_ERASE_TRIG]
							&& q.ctrl[`EEA_B_ERASE_EN] && q.arm_erase;
						d.ctrl[`EEA_B_WRITE_TRIG] = reg_wdata_i[`EEA_B_WRITE_TRIG]
							&& q.ctrl[`EEA_B_WRITE_EN] && q.arm_write;
						d.ctrl[`EEA_B_READ_TRIG] = reg_wdata_i[`EEA_B_READ_TRIG]
							&& q.ctrl[`EEA_B_READ_EN];
					end
				end
			endcase
		end

		// sequencer
		case (q.state)
			EEA_IDLE: begin
				if (q.ctrl[`EEA_B_ERASE_TRIG] && q.ctrl[`EEA_B_ERASE_EN]) begin
					d.state = EEA_TIMED;
					d.op_erase = 1'b1;
					d.tmr_start = 1'b1;
					d.tmr_load = q.ctrl[`EEA_B_TIME_SEL] ? 17'(ERASE1_CYC) : 17'(ERASE0_CYC);
				end else if (q.ctrl[`EEA_B_WRITE_TRIG] && q.ctrl[`EEA_B_WRITE_EN]) begin
					d.state = EEA_TIMED;
					d.op_erase = 1'b0;
					d.tmr_start = 1'b1;
					d.tmr_load = q.ctrl[`EEA_B_TIME_SEL] ? 17'(WRITE1_CYC) : 17'(WRITE0_CYC);
				end else if (q.ctrl[`EEA_B_READ_TRIG] && q.ctrl[`EEA_B_READ_EN]) begin
					d.state = EEA_READ;
				end
			end
			EEA_READ: begin
				d.data = arr_rdata;
				d.ctrl[`EEA_B_READ_TRIG] = 1'b0;
				if (page && q.addr_lo[3:0] != `EEA_LOW_MAX) begin
					d.addr_lo[3:0] = q.addr_lo[3:0] + 4'h1;
				end
				d.state = EEA_IDLE;
			end
			EEA_TIMED: begin
				if (tmr_done) begin
					d.state = EEA_COMMIT;
					d.idx = 4'h0;
				end
			end
			EEA_COMMIT: begin
				d.idx = q.idx + 4'h1;
				if (!page || q.idx == `EEA_LOW_MAX) begin
					d.state = EEA_IDLE;
					if (q.op_erase) begin
						d.ctrl[`EEA_B_ERASE_TRIG] = 1'b0;
						d.ctrl[`EEA_B_ERASE_EN] = 1'b0;
					end else begin
						d.ctrl[`EEA_B_WRITE_TRIG] = 1'b0;
						d.ctrl[`EEA_B_WRITE_EN] = 1'b0;
					end
				end
			end
			default: d.state = EEA_IDLE;
		endcase

		// end-of-cycle request flags, set beats clear
		d.irq_flag = q.irq_flag && !irq_flag_clr_i;
		d.mf_flag = q.mf_flag && !mf_flag_clr_i;
		if (q.state == EEA_COMMIT && d.state == EEA_IDLE) begin
			d.irq_flag = 1'b1;
			d.mf_flag = 1'b1;
		end

		// buffer clears when an enable falls, never when it rises
		if ((q.ctrl[`EEA_B_ERASE_EN] && !d.ctrl[`EEA_B_ERASE_EN])
			|| (q.ctrl[`EEA_B_WRITE_EN] && !d.ctrl[`EEA_B_WRITE_EN])) begin
			d.tag = 16'h0000;
			d.pbuf = '0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
			q.state <= EEA_IDLE;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata_o = q.rdata;
	assign eeprom_irq_flag_o = q.irq_flag;
	assign mf_irq_flag_o = q.mf_flag;

endmodule // eea_ctrl

// ---- bench/eea_ctrl_monitor.sv ----
/*
 checker on the eeprom access controller ports: flags, readback, cycle span.
 assumes the bind passes the shortened erase cycle counts.
*/
module eea_ctrl_monitor import eea_pkg::*; #(
	parameter int E0 = 20,
	parameter int E1 = 40
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// register port
	input wire logic [1:0] reg_sel_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	// flags
	input wire logic irq_flag_clr_i,
	input wire logic mf_flag_clr_i,
	input wire logic eeprom_irq_flag_o,
	input wire logic mf_irq_flag_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [15:0] cnt_q;
	// cycles since the last erase or write trigger write
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			cnt_q <= 16'h0000;
		else if (reg_wr_i && reg_sel_i == 2'h3 && (reg_wdata_i & 8'h24) != 8'h00)
			cnt_q <= 16'h0001;
		else if (cnt_q != 16'hFFFF)
			cnt_q <= cnt_q + 16'h0001;
	end
	property p_high_zero;
		reg_sel_i == 2'h1 |=> reg_rdata_o[7:3] == 5'h00;
	endproperty
	a_high_zero: assert property (p_high_zero) else $error("high address upper bits set");
	property p_trig_drop;
		reg_wr_i && reg_sel_i == 2'h3 && (reg_wdata_i & 8'h4A) == 8'h00 && $past(reg_sel_i) == 2'h3
			&& !$past(reg_wr_i) && (reg_rdata_o & 8'h6F) == 8'h00 ##1 reg_sel_i == 2'h3
			|=> (reg_rdata_o & 8'h25) == 8'h00;
	endproperty
	a_trig_drop: assert property (p_trig_drop) else $error("trigger kept without enable");
	property p_pair;
		$rose(eeprom_irq_flag_o) |-> mf_irq_flag_o;
	endproperty
	a_pair: assert property (p_pair) else $error("flags not raised together");
	property p_irq_hold;
		eeprom_irq_flag_o && !irq_flag_clr_i |=> eeprom_irq_flag_o;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("eeprom flag dropped");
	property p_mf_hold;
		mf_irq_flag_o && !mf_flag_clr_i |=> mf_irq_flag_o;
	endproperty
	a_mf_hold: assert property (p_mf_hold) else $error("multi-function flag dropped");
	property p_clear;
		(irq_flag_clr_i && mf_flag_clr_i) [*2] |=> !eeprom_irq_flag_o && !mf_irq_flag_o;
	endproperty
	a_clear: assert property (p_clear) else $error("flags not cleared");
	property p_span;
		$rose(eeprom_irq_flag_o) |-> int'(cnt_q) >= E0 && int'(cnt_q) <= E1 + 40;
	endproperty
	a_span: assert property (p_span) else $error("cycle length out of range");
	property p_done_clear;
		$rose(eeprom_irq_flag_o) && reg_sel_i == 2'h3 |=> (reg_rdata_o & 8'h6C) == 8'h00;
	endproperty
	a_done_clear: assert property (p_done_clear) else $error("enable or trigger left set");
	c_done: cover property ($rose(eeprom_irq_flag_o));
	c_data: cover property (reg_wr_i && reg_sel_i == 2'h2);
	c_clear: cover property (irq_flag_clr_i && eeprom_irq_flag_o);
endmodule // eea_ctrl_monitor

bind eea_ctrl eea_ctrl_monitor #(.E0(ERASE0_CYC), .E1(ERASE1_CYC)) u_mon (.ref_clk_i(ref_clk_i),
	.rst_n_i(rst_n_i), .reg_sel_i(reg_sel_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o), .irq_flag_clr_i(irq_flag_clr_i), .mf_flag_clr_i(mf_flag_clr_i),
	.eeprom_irq_flag_o(eeprom_irq_flag_o), .mf_irq_flag_o(mf_irq_flag_o));

// ---- bench/eea_core_model.sv ----
/*
 core-side register port model: one write or read per call, two writes per act call.
 assumes read data arrives one cycle after the select.
*/
module eea_core_model (
	input wire logic ref_clk_i,
	input wire logic [7:0] reg_rdata_i,
	output logic [1:0] reg_sel_o,
	output logic reg_wr_o,
	output logic [7:0] reg_wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		reg_sel_o = 2'h0;
		reg_wr_o = 1'b0;
		reg_wdata_o = 8'h00;
	end
	// one-cycle strobe per write, with no wait on a running cycle
	task automatic wr(input logic [1:0] s, input logic [7:0] d);
		@(posedge ref_clk_i);
		reg_sel_o <= s;
		reg_wdata_o <= d;
		reg_wr_o <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_o <= 1'b0;
		reg_wdata_o <= ~d;
	endtask
	// enable then trigger with no write between
	task automatic act(input logic [7:0] en, input logic [7:0] trg);
		wr(2'h3, en);
		wr(2'h3, en | trg);
	endtask
	task automatic rd(input logic [1:0] s, output logic [7:0] d);
		@(posedge ref_clk_i);
		reg_sel_o <= s;
		repeat (3) @(posedge ref_clk_i);
		#1 d = reg_rdata_i;
	endtask
endmodule // eea_core_model

// ---- bench/eea_ctrl_tb.sv ----
/*
 testbench for the eeprom access controller.
 assumes shortened cycle counts and the core model on the register port.
*/
module eea_ctrl_tb import eea_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int E0 = 20;
	localparam int W0 = 30;
	localparam int E1 = 40;
	localparam int W1 = 50;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic clr = 1'b0;
	logic clr_mf = 1'b0;
	logic [1:0] sel;
	logic wr;
	logic [7:0] wd;
	logic [7:0] rdat;
	logic irq;
	logic mf;
	int failures = 0;
	int checks_done = 0;
	always #25 clk = ~clk;
	eea_core_model u_core (.ref_clk_i(clk), .reg_rdata_i(rdat), .reg_sel_o(sel), .reg_wr_o(wr), .reg_wdata_o(wd));
	eea_ctrl #(.ERASE0_CYC(E0), .WRITE0_CYC(W0), .ERASE1_CYC(E1), .WRITE1_CYC(W1)) DUT (.ref_clk_i(clk),
		.rst_n_i(rst_n), .reg_sel_i(sel), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rdata_o(rdat),
		.irq_flag_clr_i(clr), .mf_flag_clr_i(clr_mf), .eeprom_irq_flag_o(irq), .mf_irq_flag_o(mf));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks=%0d failures=%0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic rc(input logic [1:0] s, input logic [7:0] e);
		logic [7:0] v;
		u_core.rd(s, v);
		chk(v, e);
	endtask
	// waits for the end flag, checks span, both flags, then clears them
	task automatic wdone(input int lo, input int hi);
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 400) begin
			@(posedge clk);
			#1 n++;
		end
		chk({7'h00, n >= lo && n <= hi}, 8'h01);
		chk({6'h00, irq, mf}, 8'h03);
		@(posedge clk);
		clr <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk({6'h00, irq, mf}, 8'h01);
		@(posedge clk);
		clr_mf <= 1'b1;
		repeat (2) @(posedge clk);
		clr <= 1'b0;
		clr_mf <= 1'b0;
		#1 chk({6'h00, irq, mf}, 8'h00);
	endtask
	task automatic bw(input logic [7:0] h, input logic [7:0] a, input logic [7:0] d, input int w);
		u_core.wr(2'h0, a);
		u_core.wr(2'h2, d);
		u_core.act(h | 8'h08, 8'h04);
		wdone(w, w + 8);
	endtask
	task automatic t_reset;
		for (int i = 0; i < 4; i++)
			rc(i[1:0], 8'h00);
		u_core.wr(2'h1, 8'hFF);
		rc(2'h1, 8'h07);
		$display("test reset done");
	endtask
	task automatic t_drop;
		rc(2'h3, 8'h00);
		u_core.wr(2'h3, 8'h20);
		rc(2'h3, 8'h00);
		u_core.wr(2'h3, 8'h04);
		rc(2'h3, 8'h00);
		u_core.wr(2'h3, 8'h01);
		rc(2'h3, 8'h00);
		repeat (60) @(posedge clk);
		chk({6'h00, irq, mf}, 8'h00);
		$display("test drop done");
	endtask
	task automatic t_timed(input logic t);
		logic [7:0] h;
		h = {t, 7'h00};
		u_core.wr(2'h1, 8'h01);
		bw(h, 8'h0E, 8'hA5, t ? W1 : W0);
		rc(2'h3, h);
		u_core.act(8'h02, 8'h01);
		rc(2'h2, 8'hA5);
		rc(2'h3, 8'h02);
		u_core.wr(2'h3, h | 8'h10);
		u_core.wr(2'h0, 8'h0E);
		for (int i = 0; i < 3; i++)
			u_core.wr(2'h2, 8'hFF);
		rc(2'h0, 8'h0F);
		u_core.act(h | 8'h50, 8'h20);
		wdone(t ? E1 : E0, (t ? E1 : E0) + 24);
		rc(2'h3, h | 8'h10);
		u_core.wr(2'h0, 8'h0E);
		u_core.act(8'h12, 8'h01);
		rc(2'h2, 8'h00);
		rc(2'h0, 8'h0F);
		u_core.wr(2'h3, 8'h13);
		rc(2'h2, 8'h00);
		rc(2'h0, 8'h0F);
		u_core.wr(2'h3, 8'h00);
		$display("test timed done");
	endtask
	task automatic t_buf_clear;
		u_core.wr(2'h1, 8'h01);
		bw(8'h00, 8'h00, 8'h3C, W0);
		bw(8'h00, 8'h01, 8'h3C, W0);
		u_core.wr(2'h3, 8'h10);
		u_core.wr(2'h0, 8'h00);
		u_core.wr(2'h2, 8'h00);
		u_core.wr(2'h3, 8'h50);
		u_core.wr(2'h3, 8'h10);
		u_core.wr(2'h2, 8'h00);
		u_core.act(8'h50, 8'h20);
		wdone(E0, E0 + 24);
		u_core.wr(2'h0, 8'h00);
		u_core.act(8'h12, 8'h01);
		rc(2'h2, 8'h3C);
		u_core.wr(2'h3, 8'h13);
		rc(2'h2, 8'h00);
		$display("test buffer clear done");
	endtask
	task automatic t_nonconsec;
		u_core.wr(2'h3, 8'h50);
		u_core.wr(2'h0, 8'h00);
		u_core.wr(2'h3, 8'h70);
		rc(2'h3, 8'h50);
		repeat (100) @(posedge clk);
		chk({6'h00, irq, mf}, 8'h00);
		u_core.wr(2'h3, 8'h00);
		rc(2'h3, 8'h00);
		$display("test nonconsecutive done");
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("ERROR t=%0t watchdog", $time);
		stop_test();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_drop();
		t_timed(1'b0);
		t_timed(1'b1);
		t_buf_clear();
		t_nonconsec();
		stop_test();
	end
endmodule // eea_ctrl_tb
